// ==== common/fss_consts.svh ====
/*
  constant definitions for the fault status summary bank: command codes,
  field positions, reset values and timing counts.
  assumes inclusion by bare name; definitions only.
*/
`ifndef FSS_CONSTS_SVH
`define FSS_CONSTS_SVH

// ----------------------------------------
// command codes
// ----------------------------------------
`define FSS_CMD_FALL_TIME 8'h65
`define FSS_CMD_SUM_BYTE 8'h78
`define FSS_CMD_SUM_WORD 8'h79
`define FSS_CMD_CLEAR_FAULTS 8'h03
`define FSS_CMD_OUTPUT_VOLTAGE_GROUP_DETAIL 8'h7A

// ----------------------------------------
// fall time fields
// ----------------------------------------
`define FSS_EXP_MSB 15
`define FSS_EXP_LSB 11
`define FSS_EXP_RESET 5'h1E
`define FSS_MAN_MSB 10
`define FSS_MAN_MIN 11'h002
`define FSS_MAN_MAX 11'h07F
`define FSS_FALL_LSB_US 250

// ----------------------------------------
// summary bit positions
// ----------------------------------------
`define FSS_BIT_BUSY 7
`define FSS_BIT_OFF 6
`define FSS_BIT_OUTPUT_OVERVOLTAGE_SUMMARY 5
`define FSS_BIT_OUTPUT_OVERCURRENT_SUMMARY 4
`define FSS_BIT_INPUT_UNDERVOLTAGE_SUMMARY 3
`define FSS_BIT_TEMP 2
`define FSS_BIT_CML 1
`define FSS_BIT_OTHER 0
`define FSS_BIT_VGRP 15
`define FSS_BIT_IGRP 14
`define FSS_BIT_INGRP 13
`define FSS_BIT_MFRGRP 12
`define FSS_BIT_PG 11
`define FSS_BIT_MISCGRP 9
`define FSS_BIT_TONMAX 2
`define FSS_CLR_BYTE 8'h80
`define FSS_CLR_WORD_BUSY 16'h0080
`define FSS_CLR_WORD_BOTH 16'h0180

`endif

// ==== common/fss_pkg.sv ====
/*
  types for the fault status summary bank.
  assumes no other package.
*/
package fss_pkg;
  typedef enum logic [3:0] {
    FSS_IDLE,
    FSS_ADDR,
    FSS_CMD,
    FSS_WDATA,
    FSS_RADDR,
    FSS_RDATA,
    FSS_ACK_WAIT,
    FSS_IGNORE
  } fss_state_t;
endpackage

// ==== rtl/fss_fault_summary.sv ====
/*
  fault status summary bank with a pmbus slave: summary byte (78h), summary
  word (79h), soft-off fall time (65h), clear-faults (03h) and the output
  voltage detail byte (7Ah) so that the max turn-on time flag can be cleared.
  assumes the bus pins and the fault inputs are asynchronous to clk_i; the
  other detailed status registers live outside and report group levels here.
*/
// Contract
// - fall exponent resets to minus two
// - fall mantissa reset loaded from nonvolatile memory
// - accept 0.5 to 31.75 ms fall times
// - below 0.5 ms applied as 0.5 ms
// - out of range write flags invalid, alerts
// - slew quantization at long times, high setpoints
// - summary byte equals word low byte
// - summary bits other than 7, 1 and 0 clear only via detail sources
// - bit 7 latches busy fault
// - writing 80h clears busy flag
// - bit 6 live converter off indicator
// - bits 5,4,3 report ov, oc, uv
// - bits 2,1,0 report temp, cml, other
// - word group flags 15,14,13,12,9 read-only
// - bit 11 live copy of power good
// - word bits 10 and 8 read zero
// - 0080h clears busy, 0180h also other
// - each alerting bit has its own mask
// - detail flags cleared by write-one or clear-faults
// - max turn-on fault sets other and voltage group
`timescale 1ns/1ps
`include "fss_consts.svh"

module fss_fault_summary #(
  parameter logic [6:0] DEV_ADDR = 7'h24
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // pmbus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  output logic alert_n_o,
  // nonvolatile defaults
  input wire logic [10:0] nvm_mantissa_i,
  // converter and detail status
  input wire logic conv_off_i,
  input wire logic power_good_pin_i,
  input wire logic busy_fault_i,
  input wire logic output_overvoltage_summary_i,
  input wire logic output_overcurrent_summary_i,
  input wire logic input_undervoltage_summary_i,
  input wire logic temp_i,
  input wire logic cml_i,
  input wire logic output_current_group_grp_i,
  input wire logic input_grp_i,
  input wire logic mfr_grp_i,
  input wire logic misc_grp_i,
  input wire logic tonmax_fault_i,
  input wire logic [7:0] alert_mask_i,
  // converter controls
  output logic [15:0] fall_time_o,
  output logic [10:0] fall_ticks_o,
  output logic invalid_data_o
);

  // ----------------------------------------
  // synchronisers and edge detection
  // ----------------------------------------
  logic [1:0] scl_sync_reg, sda_sync_reg;
  logic [4:0] ev_sync1_reg, ev_sync2_reg;
  logic scl_d_reg, sda_d_reg;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      ev_sync1_reg <= 5'h00;
      ev_sync2_reg <= 5'h00;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_i};
      sda_sync_reg <= {sda_sync_reg[0], sda_i};
      scl_d_reg <= scl_sync_reg[1];
      sda_d_reg <= sda_sync_reg[1];
      ev_sync1_reg <= {busy_fault_i, tonmax_fault_i, conv_off_i, power_good_pin_i, 1'b0};
      ev_sync2_reg <= ev_sync1_reg;
    end
  end
  logic scl_s, sda_s, scl_rise, scl_fall, start_c, stop_c;
  assign scl_s = scl_sync_reg[1];
  assign sda_s = sda_sync_reg[1];
  assign scl_rise = scl_s && !scl_d_reg;
  assign scl_fall = !scl_s && scl_d_reg;
  assign start_c = scl_s && scl_d_reg && sda_d_reg && !sda_s;
  assign stop_c = scl_s && scl_d_reg && !sda_d_reg && sda_s;

  // detail levels pass two flops before use
  logic [9:0] lvl_sync1_reg, lvl_sync2_reg;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      lvl_sync1_reg <= 10'h000;
      lvl_sync2_reg <= 10'h000;
    end else begin
      lvl_sync1_reg <= {output_overvoltage_summary_i, output_overcurrent_summary_i, input_undervoltage_summary_i, temp_i, cml_i,
                        output_current_group_grp_i, input_grp_i, mfr_grp_i, misc_grp_i, 1'b0};
      lvl_sync2_reg <= lvl_sync1_reg;
    end
  end
  logic busy_ev, tonmax_ev, off_live, pg_live;
  logic busy_d_reg, tonmax_d_reg;
  assign busy_ev = ev_sync2_reg[4] && !busy_d_reg;
  assign tonmax_ev = ev_sync2_reg[3] && !tonmax_d_reg;
  assign off_live = ev_sync2_reg[2];
  assign pg_live = ev_sync2_reg[1];
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      busy_d_reg <= 1'b0;
      tonmax_d_reg <= 1'b0;
    end else begin
      busy_d_reg <= ev_sync2_reg[4];
      tonmax_d_reg <= ev_sync2_reg[3];
    end
  end

  // ----------------------------------------
  // pmbus slave engine
  // ----------------------------------------
  fss_pkg::fss_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg, cmd_reg, wlo_reg, whi_reg;
  logic [1:0] wbyte_cnt_reg;
  logic ack_drive_reg, rd_drive_reg, rd_byte_reg, read_mode_reg;
  logic [15:0] rd_word;
  logic wr_done_pulse;
  logic [15:0] wr_data;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg <= fss_pkg::FSS_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      cmd_reg <= 8'h00;
      wlo_reg <= 8'h00;
      whi_reg <= 8'h00;
      wbyte_cnt_reg <= 2'h0;
      ack_drive_reg <= 1'b0;
      rd_drive_reg <= 1'b0;
      rd_byte_reg <= 1'b0;
      read_mode_reg <= 1'b0;
      wr_done_pulse <= 1'b0;
      wr_data <= 16'h0000;
    end else begin
      wr_done_pulse <= 1'b0;
      if (stop_c) begin
        if (state_reg != fss_pkg::FSS_IGNORE && !read_mode_reg &&
            ((wbyte_cnt_reg == 2'h1 && cmd_reg == `FSS_CMD_SUM_BYTE) ||
             (wbyte_cnt_reg == 2'h1 && cmd_reg == `FSS_CMD_OUTPUT_VOLTAGE_GROUP_DETAIL) ||
             (wbyte_cnt_reg == 2'h2) ||
             (wbyte_cnt_reg == 2'h0 && cmd_reg == `FSS_CMD_CLEAR_FAULTS))) begin
          wr_done_pulse <= 1'b1;
          wr_data <= (wbyte_cnt_reg == 2'h2) ? {whi_reg, wlo_reg} : {8'h00, wlo_reg};
        end
        state_reg <= fss_pkg::FSS_IDLE;
        ack_drive_reg <= 1'b0;
        rd_drive_reg <= 1'b0;
      end else if (start_c) begin
        state_reg <= fss_pkg::FSS_ADDR;
        bit_cnt_reg <= 4'h0;
        read_mode_reg <= 1'b0;
        ack_drive_reg <= 1'b0;
        rd_drive_reg <= 1'b0;
      end else begin
        unique case (state_reg)
          fss_pkg::FSS_IDLE, fss_pkg::FSS_IGNORE: begin
          end
          fss_pkg::FSS_ADDR, fss_pkg::FSS_CMD, fss_pkg::FSS_WDATA: begin
            if (scl_rise && bit_cnt_reg < 4'h8) begin
              shift_reg <= {shift_reg[6:0], sda_s};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == 4'h8) begin
              bit_cnt_reg <= 4'h9;
              if (state_reg == fss_pkg::FSS_ADDR && shift_reg[7:1] != DEV_ADDR) begin
                state_reg <= fss_pkg::FSS_IGNORE;
              end else begin
                ack_drive_reg <= 1'b1;
              end
            end else if (scl_fall && bit_cnt_reg == 4'h9) begin
              ack_drive_reg <= 1'b0;
              bit_cnt_reg <= 4'h0;
              if (state_reg == fss_pkg::FSS_ADDR && shift_reg[0]) begin
                read_mode_reg <= 1'b1;
                rd_byte_reg <= 1'b0;
                state_reg <= fss_pkg::FSS_RDATA;
                rd_drive_reg <= 1'b1;
                shift_reg <= rd_word[7:0];
              end else if (state_reg == fss_pkg::FSS_ADDR) begin
                state_reg <= fss_pkg::FSS_CMD;
                wbyte_cnt_reg <= 2'h0;
              end else if (state_reg == fss_pkg::FSS_CMD) begin
                cmd_reg <= shift_reg;
                state_reg <= fss_pkg::FSS_WDATA;
              end else begin
                if (wbyte_cnt_reg == 2'h0) begin
                  wlo_reg <= shift_reg;
                end
                // the stop's scl rise shifts one more bit, so keep the high byte here
                if (wbyte_cnt_reg == 2'h1) begin
                  whi_reg <= shift_reg;
                end
                if (wbyte_cnt_reg != 2'h3) begin
                  wbyte_cnt_reg <= wbyte_cnt_reg + 2'h1;
                end
              end
            end
          end
          fss_pkg::FSS_RDATA: begin
            if (scl_fall && bit_cnt_reg < 4'h7) begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == 4'h7) begin
              rd_drive_reg <= 1'b0;
              bit_cnt_reg <= 4'h8;
            end else if (scl_rise && bit_cnt_reg == 4'h8) begin
              // master nack ends the read
              state_reg <= sda_s ? fss_pkg::FSS_IGNORE : fss_pkg::FSS_ACK_WAIT;
            end
          end
          fss_pkg::FSS_ACK_WAIT: begin
            if (scl_fall) begin
              bit_cnt_reg <= 4'h0;
              rd_byte_reg <= 1'b1;
              rd_drive_reg <= 1'b1;
              shift_reg <= rd_byte_reg ? 8'hFF : rd_word[15:8];
              state_reg <= fss_pkg::FSS_RDATA;
            end
          end
          default: state_reg <= fss_pkg::FSS_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // summary and detail state
  // ----------------------------------------
  logic busy_reg, tonmax_reg, invalid_reg;
  logic [15:0] fall_reg;
  logic man_loaded_reg;
  logic wr_fall, wr_byte, wr_word, wr_vdet, wr_clr;
  assign wr_fall = wr_done_pulse && cmd_reg == `FSS_CMD_FALL_TIME;
  assign wr_byte = wr_done_pulse && cmd_reg == `FSS_CMD_SUM_BYTE;
  assign wr_word = wr_done_pulse && cmd_reg == `FSS_CMD_SUM_WORD;
  assign wr_vdet = wr_done_pulse && cmd_reg == `FSS_CMD_OUTPUT_VOLTAGE_GROUP_DETAIL;
  assign wr_clr = wr_done_pulse && cmd_reg == `FSS_CMD_CLEAR_FAULTS;

  // set wins over clear on every latched flag
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      busy_reg <= 1'b0;
    end else if (busy_ev) begin
      busy_reg <= 1'b1;
    end else if ((wr_byte && wr_data[7:0] == `FSS_CLR_BYTE) ||
                 (wr_word && (wr_data == `FSS_CLR_WORD_BUSY || wr_data == `FSS_CLR_WORD_BOTH)) ||
                 wr_clr) begin
      busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tonmax_reg <= 1'b0;
    end else if (tonmax_ev) begin
      tonmax_reg <= 1'b1;
    end else if (wr_clr || (wr_vdet && wr_data[`FSS_BIT_TONMAX]) ||
                 (wr_word && wr_data == `FSS_CLR_WORD_BOTH)) begin
      tonmax_reg <= 1'b0;
    end
  end

  function automatic logic fall_ok(input logic [15:0] v);
    fall_ok = v[`FSS_EXP_MSB:`FSS_EXP_LSB] == `FSS_EXP_RESET && !v[`FSS_MAN_MSB] &&
              v[`FSS_MAN_MSB:0] <= `FSS_MAN_MAX;
  endfunction

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      fall_reg <= {`FSS_EXP_RESET, 11'h000};
      man_loaded_reg <= 1'b0;
      invalid_reg <= 1'b0;
    end else begin
      if (!man_loaded_reg) begin
        fall_reg[`FSS_MAN_MSB:0] <= nvm_mantissa_i;
        man_loaded_reg <= 1'b1;
      end else if (wr_fall && fall_ok(wr_data)) begin
        fall_reg <= wr_data;
      end
      if (wr_fall && !fall_ok(wr_data)) begin
        invalid_reg <= 1'b1;
      end else if (wr_clr || (wr_word && wr_data == `FSS_CLR_WORD_BOTH)) begin
        invalid_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // read image and alert
  // ----------------------------------------
  logic [7:0] sum_byte;
  logic [15:0] sum_word;
  logic other_sum;
  assign other_sum = tonmax_reg;
  assign sum_byte = {busy_reg, off_live, lvl_sync2_reg[9], lvl_sync2_reg[8],
                     lvl_sync2_reg[7], lvl_sync2_reg[6], lvl_sync2_reg[5] | invalid_reg, other_sum};
  assign sum_word = {tonmax_reg | lvl_sync2_reg[9], lvl_sync2_reg[4] | lvl_sync2_reg[8],
                     lvl_sync2_reg[3] | lvl_sync2_reg[7], lvl_sync2_reg[2], pg_live, 1'b0,
                     lvl_sync2_reg[1], 1'b0, sum_byte};
  always_comb begin
    unique case (cmd_reg)
      `FSS_CMD_FALL_TIME: rd_word = fall_reg;
      `FSS_CMD_SUM_BYTE: rd_word = {8'hFF, sum_byte};
      `FSS_CMD_SUM_WORD: rd_word = sum_word;
      `FSS_CMD_OUTPUT_VOLTAGE_GROUP_DETAIL: rd_word = {8'hFF, {lvl_sync2_reg[9], 4'h0, tonmax_reg, 2'h0}};
      default: rd_word = 16'hFFFF;
    endcase
  end

  logic [7:0] alert_src;
  logic alert_reg;
  assign alert_src = {busy_reg, 1'b0, sum_byte[5:0]};
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      alert_reg <= 1'b0;
    end else begin
      alert_reg <= |(alert_src & ~alert_mask_i);
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // slope quantization happens in the analog slew; ticks are exact here
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      fall_ticks_o <= `FSS_MAN_MIN;
    end else begin
      fall_ticks_o <= (fall_reg[`FSS_MAN_MSB:0] < `FSS_MAN_MIN) ? `FSS_MAN_MIN : fall_reg[`FSS_MAN_MSB:0];
    end
  end
  assign fall_time_o = fall_reg;
  assign invalid_data_o = invalid_reg;
  assign alert_n_o = !alert_reg;
  assign sda_o = rd_drive_reg ? shift_reg[7] : 1'b0;
  assign sda_oe_n_o = !(ack_drive_reg || (rd_drive_reg && !shift_reg[7]));

endmodule

// ==== testbench/fss_fault_summary_properties.sv ====
/*
  port-level properties of the fault status summary bank.
  assumes it is bound to fss_fault_summary; one clock domain, sync reset.
*/
`timescale 1ns/1ps
module fss_fault_summary_properties (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // watched ports
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  input wire logic [10:0] nvm_mantissa_i,
  input wire logic [15:0] fall_time_o,
  input wire logic [10:0] fall_ticks_o,
  input wire logic invalid_data_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // ----------------------------------------
  // fall time
  // ----------------------------------------
  sequence s_settled;
    $stable(fall_time_o) [*2];
  endsequence
  property p_exp_fixed;
    fall_time_o[15:11] == 5'h1E;
  endproperty
  a_exp_fixed: assert property (p_exp_fixed) else $error("fall exponent left minus two");
  property p_nvm_load;
    $fell(sys_rst_i) |-> ##[1:2] fall_time_o[10:0] == nvm_mantissa_i;
  endproperty
  a_nvm_load: assert property (p_nvm_load) else $error("fall mantissa not loaded after reset");
  property p_ticks_min;
    fall_ticks_o >= 11'h002;
  endproperty
  a_ticks_min: assert property (p_ticks_min) else $error("applied fall below two counts");
  property p_ticks_max;
    fall_ticks_o <= 11'h07F;
  endproperty
  a_ticks_max: assert property (p_ticks_max) else $error("applied fall above range");
  property p_ticks_map;
    s_settled |-> fall_ticks_o == ((fall_time_o[10:0] < 11'h002) ? 11'h002 : fall_time_o[10:0]);
  endproperty
  a_ticks_map: assert property (p_ticks_map) else $error("applied fall differs from register");
  // invalid data must leave the register alone
  property p_invalid_hold;
    $rose(invalid_data_o) |-> $stable(fall_time_o) [*3];
  endproperty
  a_invalid_hold: assert property (p_invalid_hold) else $error("invalid fall write was stored");
  // ----------------------------------------
  // bus pins
  // ----------------------------------------
  property p_sda_od;
    !sda_oe_n_o |-> !sda_o;
  endproperty
  a_sda_od: assert property (p_sda_od) else $error("sda driven high");
  // data may only move while scl is low, else it reads as start or stop
  property p_sda_scl_low;
    $changed(sda_oe_n_o) |-> !scl_i;
  endproperty
  a_sda_scl_low: assert property (p_sda_scl_low) else $error("sda moved while scl high");
endmodule

// ==== testbench/fss_host_model.sv ====
/*
  pmbus host model: bit-level master driving scl and pulling sda low.
  assumes the bench resolves the open-drain sda line with a pull-up.
*/
`timescale 1ns/1ps
module fss_host_model (
  // clock and line
  input wire logic clk_i,
  input wire logic sda_line_i,
  // pins
  output logic scl_o,
  output logic sda_n_o
);
  localparam logic [6:0] ADDR = 7'h24;
  int nacks = 0;
  initial begin
    scl_o = 1'b1;
    sda_n_o = 1'b1;
  end
  // three ticks a bit: 48 ns scl period, scl low twice as long as high
  task automatic tick();
    repeat (4) @(negedge clk_i);
  endtask
  task automatic bit_io(input logic d, output logic r);
    sda_n_o = d;
    tick();
    scl_o = 1'b1;
    tick();
    r = sda_line_i;
    scl_o = 1'b0;
    tick();
  endtask
  task automatic start();
    sda_n_o = 1'b1;
    tick();
    scl_o = 1'b1;
    tick();
    sda_n_o = 1'b0;
    tick();
    scl_o = 1'b0;
    tick();
  endtask
  task automatic stop();
    sda_n_o = 1'b0;
    tick();
    scl_o = 1'b1;
    tick();
    sda_n_o = 1'b1;
    tick();
  endtask
  task automatic byte_io(input logic [7:0] d, input logic mack, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], a);
      q[i] = a;
    end
    bit_io(mack, a);
  endtask
  // word data goes low byte first
  task automatic wr(input logic [7:0] cmd, input logic [15:0] d, input int n);
    logic [31:0] s;
    logic [7:0] q;
    logic a;
    s = {d, cmd, ADDR, 1'b0};
    start();
    for (int k = 0; k < n + 2; k++) begin
      byte_io(s[8*k +: 8], 1'b1, q, a);
      if (a) nacks++;
    end
    stop();
  endtask
  task automatic rd(input logic [7:0] cmd, input int n, output logic [15:0] q);
    logic [7:0] b;
    logic a;
    q = '0;
    start();
    byte_io({ADDR, 1'b0}, 1'b1, b, a);
    if (a) nacks++;
    byte_io(cmd, 1'b1, b, a);
    if (a) nacks++;
    start();
    byte_io({ADDR, 1'b1}, 1'b1, b, a);
    if (a) nacks++;
    for (int k = 0; k < n; k++) begin
      byte_io(8'hFF, k == n - 1, b, a);
      q[8*k +: 8] = b;
    end
    stop();
  endtask
endmodule

// ==== testbench/tb_fss_fault_summary.sv ====
/*
  self-checking bench for the fault status summary bank over pmbus.
  assumes fss_host_model as bus master and the bound property checker.
*/
`timescale 1ns/1ps
module tb_fss_fault_summary;
  localparam logic [10:0] NVM = 11'h011;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [12:0] flt = '0;
  logic [7:0] mask = '0;
  logic scl;
  logic host_sda_n;
  logic sda_o;
  logic sda_oe_n_o;
  logic alert_n_o;
  logic [15:0] fall_time_o;
  logic [10:0] fall_ticks_o;
  logic invalid_data_o;
  logic [15:0] w;
  logic [15:0] b;
  int mismatches = 0;
  int samples_checked = 0;
  wire logic sda_line = host_sda_n & (sda_oe_n_o | sda_o);
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  fss_fault_summary fss_fault_summary_i (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o), .alert_n_o(alert_n_o), .nvm_mantissa_i(NVM), .conv_off_i(flt[0]),
    .power_good_pin_i(flt[1]), .busy_fault_i(flt[11]), .output_overvoltage_summary_i(flt[2]), .output_overcurrent_summary_i(flt[3]),
    .input_undervoltage_summary_i(flt[4]), .temp_i(flt[5]), .cml_i(flt[6]), .output_current_group_grp_i(flt[7]), .input_grp_i(flt[8]),
    .mfr_grp_i(flt[9]), .misc_grp_i(flt[10]), .tonmax_fault_i(flt[12]), .alert_mask_i(mask),
    .fall_time_o(fall_time_o), .fall_ticks_o(fall_ticks_o), .invalid_data_o(invalid_data_o));
  fss_host_model fss_host_model_i (.clk_i(clk_i), .sda_line_i(sda_line), .scl_o(scl), .sda_n_o(host_sda_n));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("mismatches %0d, samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // async inputs need the synchroniser and a register stage
  task automatic settle();
    repeat (12) @(negedge clk_i);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    fss_host_model_i.rd(8'h65, 2, w);
    chk("fall reset", {5'h1E, NVM}, w);
    chk("ticks reset", {5'h00, NVM}, {5'h00, fall_ticks_o});
    fss_host_model_i.rd(8'h79, 2, w);
    chk("word reset", 16'h0000, w);
  endtask
  task automatic t_summary();
    int pos [11] = '{6, 11, 5, 4, 3, 2, 1, 14, 13, 12, 9};
    for (int i = 0; i < 11; i++) begin
      flt = 13'h0001 << i;
      settle();
      fss_host_model_i.rd(8'h79, 2, w);
      fss_host_model_i.rd(8'h78, 1, b);
      chk("summary bit", 16'h0001, {15'h0000, w[pos[i]]});
      chk("unsupported bits", 16'h0000, w & 16'h0500);
      chk("byte vs word", {8'h00, w[7:0]}, b);
      flt = '0;
      settle();
      fss_host_model_i.rd(8'h79, 2, w);
      chk("summary cleared", 16'h0000, w);
    end
  endtask
  task automatic t_busy();
    logic [7:0] cmd [3] = '{8'h78, 8'h79, 8'h79};
    logic [15:0] clr [3] = '{16'h0080, 16'h0080, 16'h0180};
    flt[12] = 1'b1;
    settle();
    flt[12] = 1'b0;
    fss_host_model_i.rd(8'h79, 2, w);
    chk("max on-time summary", 16'h8001, w);
    fss_host_model_i.wr(8'h7A, 16'h0004, 1);
    fss_host_model_i.rd(8'h79, 2, w);
    chk("max on-time cleared", 16'h0000, w);
    for (int k = 0; k < 3; k++) begin
      flt[11] = 1'b1;
      flt[12] = k == 2;
      settle();
      flt[11] = 1'b0;
      flt[12] = 1'b0;
      settle();
      fss_host_model_i.rd(8'h78, 1, b);
      chk("busy latched", {8'h00, 7'h40, k == 2}, b);
      fss_host_model_i.wr(cmd[k], clr[k], k == 0 ? 1 : 2);
      fss_host_model_i.rd(8'h79, 2, w);
      chk("busy cleared", 16'h0000, w);
    end
  endtask
  task automatic t_alert();
    flt[5] = 1'b1;
    settle();
    chk("alert unmasked", 16'h0000, {15'h0000, alert_n_o});
    mask = 8'h04;
    settle();
    chk("alert masked", 16'h0001, {15'h0000, alert_n_o});
    flt[5] = 1'b0;
    mask = 8'h00;
    settle();
  endtask
  task automatic t_fall();
    logic [15:0] fv [5] = '{16'hF002, 16'hF07F, 16'hF001, 16'hF080, 16'hF802};
    logic [15:0] exp_f;
    logic [10:0] t;
    logic ok;
    exp_f = {5'h1E, NVM};
    for (int k = 0; k < 5; k++) begin
      ok = fv[k][15:11] == 5'h1E && fv[k][10:0] <= 11'h07F;
      if (ok) exp_f = fv[k];
      t = exp_f[10:0] < 11'h002 ? 11'h002 : exp_f[10:0];
      fss_host_model_i.wr(8'h65, fv[k], 2);
      settle();
      chk("fall register", exp_f, fall_time_o);
      chk("applied ticks", {5'h00, t}, {5'h00, fall_ticks_o});
      chk("invalid flag", {15'h0000, !ok}, {15'h0000, invalid_data_o});
      fss_host_model_i.rd(8'h65, 2, w);
      chk("fall readback", exp_f, w);
    end
    fss_host_model_i.rd(8'h78, 1, b);
    chk("comm fault summary", 16'h0002, b & 16'h0002);
    chk("invalid alert", 16'h0000, {15'h0000, alert_n_o});
    fss_host_model_i.wr(8'h03, 16'h0000, 0);
    settle();
    chk("invalid cleared", 16'h0000, {15'h0000, invalid_data_o});
    chk("alert released", 16'h0001, {15'h0000, alert_n_o});
  endtask
  initial begin
    repeat (2) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    t_reset();
    t_summary();
    t_busy();
    t_alert();
    t_fall();
    chk("host nacks", 16'h0000, fss_host_model_i.nacks[15:0]);
    conclude();
  end
  // about two and a half times the expected run length
  initial begin
    repeat (80000) @(posedge clk_i);
    mismatches++;
    conclude();
  end
endmodule
bind fss_fault_summary fss_fault_summary_properties fss_fault_summary_properties_i (.*);
